/* rtl/bcr_pkg.sv */
// Package with register layout, reset loading and carrier types for the buck control register bank
package bcr_pkg;

    // Register count and widths
    localparam int REG_COUNT = 7;
    localparam int REG_WIDTH = 8;
    localparam int ADDR_WIDTH = 3;

    // Register indices within the bank (no offsets are printed, so these are local)
    localparam logic [2:0] IDX_BUCK_ONE_B_CONFIG = 3'h0;
    localparam logic [2:0] IDX_BUCK_TWO_VOLTAGE = 3'h1;
    localparam logic [2:0] IDX_BUCK_TWO_STANDBY_VOLTAGE = 3'h2;
    localparam logic [2:0] IDX_BUCK_TWO_SLEEP_VOLTAGE = 3'h3;
    localparam logic [2:0] IDX_BUCK_TWO_MODE = 3'h4;
    localparam logic [2:0] IDX_BUCK_TWO_CONFIG = 3'h5;
    localparam logic [2:0] IDX_BUCK_THREE_VOLTAGE = 3'h6;

    // Implemented-bit masks per register kind
    localparam logic [7:0] MASK_CONFIG = 8'h7D;
    localparam logic [7:0] MASK_VOLT_RANGE = 8'h3F;
    localparam logic [7:0] MASK_VOLT = 8'h1F;
    localparam logic [7:0] MASK_MODE = 8'h2F;

    // Field positions in configuration registers
    localparam int CONF_STEP_RATE_BIT = 6;
    localparam int CONF_PHASE_LSB = 4;
    localparam int CONF_FREQ_LSB = 2;
    localparam int CONF_ILIM_BIT = 0;

    // Field positions in voltage and mode registers
    localparam int VOLT_CODE_LSB = 0;
    localparam int VOLT_RANGE_BIT = 5;
    localparam int MODE_OFF_SLEEP_BIT = 5;
    localparam int MODE_SWITCH_LSB = 0;

    // Value of the whole bank while the configuration memory has not yet delivered
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // Timing of one voltage step in each stepping rate, in ns, and clock period
    localparam int CLK_PERIOD_NS = 100;
    localparam int STEP_FAST_NS = 2000;
    localparam int STEP_SLOW_NS = 4000;
    localparam int STEP_FAST_CYCLES = (STEP_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_SLOW_CYCLES = (STEP_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Loader state
    typedef enum logic [1:0] {
        BCR_LOAD_WAIT,
        BCR_LOAD_RUN,
        BCR_LOAD_DONE
    } bcr_load_e;

    // Configuration fields driven to one buck's power stage
    typedef struct packed {
        logic step_rate;
        logic [1:0] phase_sel;
        logic [1:0] freq_sel;
        logic current_limit;
    } bcr_conf_s;

    // Voltage fields of one buck's voltage register
    typedef struct packed {
        logic range_high;
        logic [4:0] code;
    } bcr_volt_s;

    // Host register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bcr_req_s;

endpackage

/* rtl/bcr_step_timer.sv */
// Stepping timer pacing one dynamic voltage step per selected interval
`timescale 1ns/1ps
`default_nettype none

module bcr_step_timer
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic slow_rate,
    // Step pulse out
    output logic step_tick
);

    // Cycle counter of the current interval
    logic [7:0] count;
    // Last count of the interval for the selected rate
    logic [7:0] last_count;

    // Interval length follows the rate bit
    always_comb
    begin
        if (slow_rate)
            last_count = 8'(bcr_pkg::STEP_SLOW_CYCLES - 1);
        else
            last_count = 8'(bcr_pkg::STEP_FAST_CYCLES - 1);
    end

    // Free-running counter; a rate change mid interval restarts on overshoot
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= 8'h00;
            step_tick <= 1'b0;
        end
        else if (count >= last_count)
        begin
            count <= 8'h00;
            step_tick <= 1'b1;
        end
        else
        begin
            count <= count + 8'h01;
            step_tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* rtl/bcr_regs.sv */
// Control register bank for the buck regulators, loaded from configuration memory
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Config bit 6 picks 2 us or 4 us steps
// - Config bits 5:4 select switching clock phase
// - Config bits 3:2 select switching frequency
// - Config bit 0 picks 2.75 A or 2.0 A
// - Buck two normal register holds voltage code
// - Bit 5 of buck two voltages selects range
// - Buck two standby register holds standby code
// - Buck two sleep register holds sleep code
// - Mode bit 5 picks off or sleep
// - Mode bits 3:0 select switching mode
// - Buck three normal register holds voltage code
// - All registers readable and writable any time
// - Reset defaults come from configuration memory
module bcr_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Host register port
    input wire bcr_pkg::bcr_req_s host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Configuration memory default feed
    input wire logic otp_valid,
    input wire logic [7:0] otp_data,
    output logic [2:0] otp_addr,
    output logic load_done,
    // Buck one B configuration outputs
    output var bcr_pkg::bcr_conf_s buck_one_b_conf,
    output logic buck_one_b_step_tick,
    // Buck two outputs
    output var bcr_pkg::bcr_volt_s buck_two_normal,
    output var bcr_pkg::bcr_volt_s buck_two_standby,
    output var bcr_pkg::bcr_volt_s buck_two_sleep,
    output logic buck_two_off_or_sleep,
    output logic [3:0] buck_two_switch_mode,
    output var bcr_pkg::bcr_conf_s buck_two_conf,
    output logic buck_two_step_tick,
    // Buck three outputs
    output logic [4:0] buck_three_code
);

    // Seven bytes stay in flops; too few to need a memory module
    // Register storage, one entry per index
    logic [7:0] regs [bcr_pkg::REG_COUNT];
    // Implemented-bit mask per index
    logic [7:0] mask [bcr_pkg::REG_COUNT];
    // Loader state and address
    bcr_pkg::bcr_load_e load_state;
    logic [2:0] load_addr;
    // Step pulses from the timers, registered once more below
    // Timers run freely, so pacing never waits on the host
    logic step_one_b;
    logic step_two;

    // Mask table per register kind
    // One table serves both the load path and the write path, so
    // unimplemented bits are cleared the same way on either
    always_comb
    begin
        mask[bcr_pkg::IDX_BUCK_ONE_B_CONFIG] = bcr_pkg::MASK_CONFIG;
        mask[bcr_pkg::IDX_BUCK_TWO_VOLTAGE] = bcr_pkg::MASK_VOLT_RANGE;
        mask[bcr_pkg::IDX_BUCK_TWO_STANDBY_VOLTAGE] = bcr_pkg::MASK_VOLT_RANGE;
        mask[bcr_pkg::IDX_BUCK_TWO_SLEEP_VOLTAGE] = bcr_pkg::MASK_VOLT_RANGE;
        mask[bcr_pkg::IDX_BUCK_TWO_MODE] = bcr_pkg::MASK_MODE;
        mask[bcr_pkg::IDX_BUCK_TWO_CONFIG] = bcr_pkg::MASK_CONFIG;
        mask[bcr_pkg::IDX_BUCK_THREE_VOLTAGE] = bcr_pkg::MASK_VOLT;
    end

    // Loader walks every index once after reset, taking one memory word per valid
    // Words must arrive in ascending index order, one per strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            load_state <= bcr_pkg::BCR_LOAD_WAIT;
            load_addr <= 3'h0;
        end
        else
        begin
            unique case (load_state)
                bcr_pkg::BCR_LOAD_WAIT:
                begin
                    // The first edge after release only arms the loader,
                    // so a word offered at that edge is ignored
                    load_state <= bcr_pkg::BCR_LOAD_RUN;
                end
                bcr_pkg::BCR_LOAD_RUN:
                begin
                    // Advance only when the memory hands over a word
                    if (otp_valid)
                    begin
                        if (load_addr == 3'(bcr_pkg::REG_COUNT - 1))
                            load_state <= bcr_pkg::BCR_LOAD_DONE;
                        else
                            load_addr <= load_addr + 3'h1;
                    end
                end
                bcr_pkg::BCR_LOAD_DONE:
                begin
                    // Parked until the next reset; defaults load once
                    load_state <= bcr_pkg::BCR_LOAD_DONE;
                end
                // The spare state code falls back to waiting
                default:
                begin
                    load_state <= bcr_pkg::BCR_LOAD_WAIT;
                end
            endcase
        end
    end

    // Loader status outputs
    // The memory address trails the pointer by one cycle; the memory
    // answers with the word for that index and raises its strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            load_done <= 1'b0;
            otp_addr <= 3'h0;
        end
        else
        begin
            load_done <= (load_state == bcr_pkg::BCR_LOAD_DONE);
            otp_addr <= load_addr;
        end
    end

    // One storage process per register; loader fills, host writes at any time
    // A host write beats a load word in the same cycle; the loader still overwrites an index it has not yet reached
    // Unimplemented bits are cleared on every path, so reads of them
    // always return zero
    for (genvar i = 0; i < bcr_pkg::REG_COUNT; i++)
    begin : g_reg
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
                regs[i] <= bcr_pkg::RESET_VALUE;
            else if (host_req.wr && host_req.addr == 3'(i))
                regs[i] <= host_req.wdata & mask[i];
            else if (load_state == bcr_pkg::BCR_LOAD_RUN && otp_valid && load_addr == 3'(i))
                regs[i] <= otp_data & mask[i];
        end
    end

    // Read port, one cycle latency; unmapped index reads zero
    // A read and a write to one index in one cycle return the old
    // contents, since the store lands at the same edge
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            host_rdata <= 8'h00;
            host_rvalid <= 1'b0;
        end
        else
        begin
            host_rvalid <= host_req.rd;
            if (host_req.rd && host_req.addr < 3'(bcr_pkg::REG_COUNT))
                host_rdata <= regs[host_req.addr];
            else
                host_rdata <= 8'h00;
        end
    end

    // Buck one B configuration fields
    // Fields lag the register by one cycle; the power stage sees a
    // settled code, never a half-written byte
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            buck_one_b_conf <= '0;
        else
        begin
            buck_one_b_conf.step_rate <= regs[bcr_pkg::IDX_BUCK_ONE_B_CONFIG][bcr_pkg::CONF_STEP_RATE_BIT];
            buck_one_b_conf.phase_sel <=
                regs[bcr_pkg::IDX_BUCK_ONE_B_CONFIG][bcr_pkg::CONF_PHASE_LSB +: 2];
            buck_one_b_conf.freq_sel <=
                regs[bcr_pkg::IDX_BUCK_ONE_B_CONFIG][bcr_pkg::CONF_FREQ_LSB +: 2];
            buck_one_b_conf.current_limit <= regs[bcr_pkg::IDX_BUCK_ONE_B_CONFIG][bcr_pkg::CONF_ILIM_BIT];
        end
    end

    // Buck two configuration fields
    // Same one-cycle lag as buck one B, so both stages update alike
    // after a host write
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            buck_two_conf <= '0;
        else
        begin
            buck_two_conf.step_rate <= regs[bcr_pkg::IDX_BUCK_TWO_CONFIG][bcr_pkg::CONF_STEP_RATE_BIT];
            buck_two_conf.phase_sel <=
                regs[bcr_pkg::IDX_BUCK_TWO_CONFIG][bcr_pkg::CONF_PHASE_LSB +: 2];
            buck_two_conf.freq_sel <=
                regs[bcr_pkg::IDX_BUCK_TWO_CONFIG][bcr_pkg::CONF_FREQ_LSB +: 2];
            buck_two_conf.current_limit <= regs[bcr_pkg::IDX_BUCK_TWO_CONFIG][bcr_pkg::CONF_ILIM_BIT];
        end
    end

    // Buck two voltage codes and ranges for normal, standby and sleep
    // Range bit and code move at one edge, so the stage never sees
    // a new code against the old range
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            buck_two_normal <= '0;
            buck_two_standby <= '0;
            buck_two_sleep <= '0;
        end
        else
        begin
            buck_two_normal.code <= regs[bcr_pkg::IDX_BUCK_TWO_VOLTAGE][bcr_pkg::VOLT_CODE_LSB +: 5];
            buck_two_standby.code <=
                regs[bcr_pkg::IDX_BUCK_TWO_STANDBY_VOLTAGE][bcr_pkg::VOLT_CODE_LSB +: 5];
            buck_two_sleep.code <=
                regs[bcr_pkg::IDX_BUCK_TWO_SLEEP_VOLTAGE][bcr_pkg::VOLT_CODE_LSB +: 5];
            // Each register carries its own range bit
            buck_two_normal.range_high <= regs[bcr_pkg::IDX_BUCK_TWO_VOLTAGE][bcr_pkg::VOLT_RANGE_BIT];
            buck_two_standby.range_high <=
                regs[bcr_pkg::IDX_BUCK_TWO_STANDBY_VOLTAGE][bcr_pkg::VOLT_RANGE_BIT];
            buck_two_sleep.range_high <=
                regs[bcr_pkg::IDX_BUCK_TWO_SLEEP_VOLTAGE][bcr_pkg::VOLT_RANGE_BIT];
        end
    end

    // Buck two mode fields
    // The switch mode code passes through undecoded; the power stage
    // owns its meaning
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            buck_two_off_or_sleep <= 1'b0;
            buck_two_switch_mode <= 4'h0;
        end
        else
        begin
            // One means sleep after a turn-off event, zero means fully off
            buck_two_off_or_sleep <= regs[bcr_pkg::IDX_BUCK_TWO_MODE][bcr_pkg::MODE_OFF_SLEEP_BIT];
            buck_two_switch_mode <= regs[bcr_pkg::IDX_BUCK_TWO_MODE][bcr_pkg::MODE_SWITCH_LSB +: 4];
        end
    end

    // Buck three normal voltage code
    // Only the code field exists here; bit 5 carries no range
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            buck_three_code <= 5'h00;
        else
            buck_three_code <= regs[bcr_pkg::IDX_BUCK_THREE_VOLTAGE][bcr_pkg::VOLT_CODE_LSB +: 5];
    end

    // Step pacing for buck one B, rate from its config bit
    // A rate change takes effect through the registered field, one
    // cycle after the write lands
    bcr_step_timer u_step_one_b
    (
        .clk(clk),
        .resetn(resetn),
        .slow_rate(buck_one_b_conf.step_rate),
        .step_tick(step_one_b)
    );

    // Step pacing for buck two
    bcr_step_timer u_step_two
    (
        .clk(clk),
        .resetn(resetn),
        .slow_rate(buck_two_conf.step_rate),
        .step_tick(step_two)
    );

    // Register the step pulses so outputs come from flip-flops
    // The extra stage costs one cycle of pulse latency; both ticks
    // share it, so their relative timing is kept
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            buck_one_b_step_tick <= 1'b0;
            buck_two_step_tick <= 1'b0;
        end
        else
        begin
            buck_one_b_step_tick <= step_one_b;
            buck_two_step_tick <= step_two;
        end
    end

endmodule

`default_nettype wire

/* verification/bcr_regs_chk.sv */
// Concurrent checks on the buck control register bank ports
`timescale 1ns/1ps
`default_nettype none

module bcr_regs_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Host port
    input wire bcr_pkg::bcr_req_s host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    // Configuration memory feed
    input wire logic otp_valid,
    input wire logic [7:0] otp_data,
    input wire logic [2:0] otp_addr,
    input wire logic load_done,
    // Buck one B
    input wire bcr_pkg::bcr_conf_s buck_one_b_conf,
    input wire logic buck_one_b_step_tick,
    // Buck two
    input wire bcr_pkg::bcr_volt_s buck_two_normal,
    input wire bcr_pkg::bcr_volt_s buck_two_standby,
    input wire bcr_pkg::bcr_volt_s buck_two_sleep,
    input wire logic buck_two_off_or_sleep,
    input wire logic [3:0] buck_two_switch_mode,
    input wire bcr_pkg::bcr_conf_s buck_two_conf,
    input wire logic buck_two_step_tick,
    // Buck three
    input wire logic [4:0] buck_three_code
);
    // One clock domain, reset cancels every attempt in flight
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Host write once loading is over, so the loader cannot overwrite it
    sequence s_wr(logic [2:0] idx);
        host_req.wr && host_req.addr == idx && load_done;
    endsequence

    // Fields appear two edges after the write: store, then output lag
    a_read_valid: assert property (host_req.rd |=> host_rvalid) else $error("read not answered");
    a_idle_quiet: assert property (!host_req.rd |=> !host_rvalid && host_rdata == 8'h00)
        else $error("read data without read");
    a_spare_zero: assert property (host_req.rd && host_req.addr == 3'h7 |=> host_rdata == 8'h00)
        else $error("spare index not zero");
    a_normal_field: assert property (s_wr(3'h1) |=> ##1 buck_two_normal == $past(host_req.wdata[5:0], 2))
        else $error("normal voltage field wrong");
    a_standby_field: assert property (s_wr(3'h2) |=> ##1 buck_two_standby == $past(host_req.wdata[5:0], 2))
        else $error("standby voltage field wrong");
    a_sleep_field: assert property (s_wr(3'h3) |=> ##1 buck_two_sleep == $past(host_req.wdata[5:0], 2))
        else $error("sleep voltage field wrong");
    a_mode_field: assert property (s_wr(3'h4) |=> ##1 {buck_two_off_or_sleep, buck_two_switch_mode} ==
        {$past(host_req.wdata[5], 2), $past(host_req.wdata[3:0], 2)}) else $error("mode fields wrong");
    a_conf_field: assert property (s_wr(3'h5) |=> ##1 buck_two_conf ==
        {$past(host_req.wdata[6:2], 2), $past(host_req.wdata[0], 2)}) else $error("config fields wrong");
    a_three_field: assert property (s_wr(3'h6) |=> ##1 buck_three_code == $past(host_req.wdata[4:0], 2))
        else $error("buck three code wrong");
    a_done_holds: assert property (load_done |=> load_done) else $error("load done dropped");
    a_tick_gap: assert property (buck_two_step_tick |=> (!buck_two_step_tick) [*8])
        else $error("step ticks too close");
    a_one_b_gap: assert property (buck_one_b_step_tick |=> (!buck_one_b_step_tick) [*8])
        else $error("buck one B ticks too close");
    a_addr_steady: assert property (load_done |=> $stable(otp_addr))
        else $error("memory address moved after load");
endmodule

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the buck control register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic otp_valid = 1'b0;
    logic [7:0] otp_data = 8'h00;
    bcr_pkg::bcr_req_s req = '0;
    logic [7:0] rdata;
    logic rvalid, done, t1b, t2, off_sl;
    logic [2:0] oaddr;
    logic [3:0] smode;
    logic [4:0] code3;
    bcr_pkg::bcr_conf_s c1b, c2;
    bcr_pkg::bcr_volt_s vn, vs, vsl;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    // Defaults fed from configuration memory and implemented-bit masks
    localparam logic [7:0] OTP [7] = '{8'hFF, 8'hA5, 8'h5A, 8'hC3, 8'hFF, 8'h96, 8'hE7};
    localparam logic [7:0] MSK [8] = '{bcr_pkg::MASK_CONFIG, bcr_pkg::MASK_VOLT_RANGE, bcr_pkg::MASK_VOLT_RANGE,
        bcr_pkg::MASK_VOLT_RANGE, bcr_pkg::MASK_MODE, bcr_pkg::MASK_CONFIG, bcr_pkg::MASK_VOLT, 8'h00};

    bcr_regs bcr_regs_inst (.clk(clk), .resetn(resetn), .host_req(req), .host_rdata(rdata), .host_rvalid(rvalid),
        .otp_valid(otp_valid), .otp_data(otp_data), .otp_addr(oaddr), .load_done(done), .buck_one_b_conf(c1b),
        .buck_one_b_step_tick(t1b), .buck_two_normal(vn), .buck_two_standby(vs), .buck_two_sleep(vsl),
        .buck_two_off_or_sleep(off_sl), .buck_two_switch_mode(smode), .buck_two_conf(c2),
        .buck_two_step_tick(t2), .buck_three_code(code3));

    // 100 ns clock
    always #50 clk = ~clk;

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // Count and report one comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One host request held for a single edge, launched off the falling edge
    task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{w, r, a, d};
        @(negedge clk);
        req = '0;
    endtask

    // Write, then let the output lag pass
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
        @(negedge clk);
    endtask

    // Read and compare the answer one edge later
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, a, 8'h00);
        chk(rdata, exp);
        chk({7'h0, rvalid}, 8'h01);
    endtask

    // Second gap between ticks, the first may straddle a rate change
    task automatic gap(input bit sel, input int exp);
        int n;
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (!(sel ? t1b : t2) && n < 100);
        end
        chk(8'(n), 8'(exp));
    endtask

    // Counts, verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 7; i++)
        begin
            otp_valid = 1'b1;
            otp_data = OTP[i];
            @(negedge clk);
        end
        otp_valid = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h0, done}, 8'h01);
        chk({5'h0, oaddr}, 8'h06);
        for (int i = 0; i < 7; i++) rd(3'(i), OTP[i] & MSK[i]);
        $display("test defaults done");
        for (int i = 0; i < 8; i++)
        begin
            wr(3'(i), 8'hFF);
            rd(3'(i), MSK[i]);
        end
        chk({off_sl, smode, code3[2:0]}, 8'hFF);
        $display("test all ones done");
        wr(3'h5, 8'h59);
        chk({2'h0, c2}, 8'h2D);
        wr(3'h0, 8'h26);
        chk({2'h0, c1b}, 8'h12);
        wr(3'h4, 8'h16);
        chk({3'h0, off_sl, smode}, 8'h06);
        wr(3'h1, 8'h2A);
        chk({2'h0, vn}, 8'h2A);
        wr(3'h2, 8'h11);
        chk({2'h0, vs}, 8'h11);
        wr(3'h3, 8'hF3);
        chk({2'h0, vsl}, 8'h33);
        wr(3'h6, 8'hEE);
        chk({3'h0, code3}, 8'h0E);
        $display("test fields done");
        acc(1'b1, 1'b1, 3'h6, 8'h05);
        chk(rdata, 8'h0E);
        rd(3'h6, 8'h05);
        $display("test write with read done");
        wr(3'h5, 8'h00);
        gap(1'b0, bcr_pkg::STEP_FAST_CYCLES);
        wr(3'h0, 8'h40);
        gap(1'b1, bcr_pkg::STEP_SLOW_CYCLES);
        $display("test step rate done");
        // Mid-run reset: outputs clear, a word at the first edge is refused
        resetn = 1'b0;
        @(negedge clk);
        chk({c2, done, off_sl}, 8'h00);
        resetn = 1'b1;
        otp_valid = 1'b1;
        otp_data = 8'h3C;
        @(negedge clk);
        // Words in reverse order with an idle cycle between strobes
        for (int i = 0; i < 7; i++)
        begin
            otp_valid = 1'b1;
            otp_data = OTP[6 - i];
            @(negedge clk);
            otp_valid = 1'b0;
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
        chk({4'h0, oaddr, done}, 8'h0D);
        for (int i = 0; i < 7; i++) rd(3'(i), OTP[6 - i] & MSK[i]);
        $display("test reload done");
        close_out();
    end
endmodule

bind bcr_regs bcr_regs_chk bcr_regs_chk_inst (.clk(clk), .resetn(resetn), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .otp_valid(otp_valid), .otp_data(otp_data),
    .otp_addr(otp_addr), .load_done(load_done), .buck_one_b_conf(buck_one_b_conf),
    .buck_one_b_step_tick(buck_one_b_step_tick), .buck_two_normal(buck_two_normal),
    .buck_two_standby(buck_two_standby), .buck_two_sleep(buck_two_sleep),
    .buck_two_off_or_sleep(buck_two_off_or_sleep), .buck_two_switch_mode(buck_two_switch_mode),
    .buck_two_conf(buck_two_conf), .buck_two_step_tick(buck_two_step_tick), .buck_three_code(buck_three_code));

`default_nettype wire
